// >>> rtl/host_regs_pkg.sv
/*
  Constants for the host controller register bank: register offsets,
  reset values, the capability fields and the access-width encoding.
  Assumes a 10-bit byte address and a 32-bit register word.
*/
`default_nettype none
package host_regs_pkg;

  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 32;
  localparam int HALF_W    = 16;
  localparam int NUM_WR    = 35;

  // Address space and regions
  localparam logic [9:0] SPACE_FIRST    = 10'h000;
  localparam logic [9:0] SPACE_LAST     = 10'h3ff;
  localparam logic [9:0] OPER_FIRST     = 10'h000;
  localparam logic [9:0] OPER_LAST      = 10'h1ff;
  localparam logic [9:0] CONF_FIRST     = 10'h300;
  localparam logic [9:0] CONF_LAST      = 10'h3ff;

  // Read-only capability and ID words, and the software reset word (writable, reads 0)
  localparam logic [9:0] OFS_CAP_LENGTH = 10'h000;
  localparam logic [9:0] OFS_IF_VERSION = 10'h002;
  localparam logic [9:0] OFS_STRUCT_PAR = 10'h004;
  localparam logic [9:0] OFS_CAP_PAR    = 10'h008;
  localparam logic [9:0] OFS_DEVICE_ID  = 10'h304;
  localparam logic [9:0] OFS_SOFTWARE_RESET   = 10'h30c;

  localparam logic [7:0]  CAP_LENGTH_VAL = 8'h20;
  localparam logic [15:0] IF_VERSION_VAL = 16'h0100;
  localparam logic [31:0] CAP_PAR_VAL    = 32'h00000086;
  localparam logic [3:0]  NUM_PORTS_DEF  = 4'h1;
  localparam logic        PORT_POWER_DEF = 1'b1;
  localparam int          NUM_PORTS_LSB  = 0;
  localparam int          PORT_POWER_BIT = 4;
  localparam int          VERSION_LSB    = 16;
  localparam int          HALF_SEL_BIT   = 1;
  localparam int          SOFTWARE_RESET_BIT   = 0;

  // Writable registers: offset and reset value, same order
  localparam logic [9:0] WR_OFS [NUM_WR] = '{
    10'h020, 10'h024, 10'h028, 10'h02c, 10'h030, 10'h060, 10'h064,
    10'h130, 10'h134, 10'h138, 10'h140, 10'h144, 10'h148,
    10'h150, 10'h154, 10'h158,
    10'h300, 10'h308, 10'h30c, 10'h310, 10'h314, 10'h318, 10'h31c,
    10'h320, 10'h324, 10'h328, 10'h32c, 10'h330, 10'h334, 10'h338,
    10'h33c, 10'h340, 10'h344, 10'h354, 10'h374
  };

  localparam logic [31:0] WR_RST [NUM_WR] = '{
    32'h00080000, 32'h00001000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00002000,
    32'h00000000, 32'hffffffff, 32'h00000000,
    32'h00000000, 32'hffffffff, 32'h00000000,
    32'h00000000, 32'hffffffff, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h0000000f,
    32'h00000000, 32'h03e81ba0, 32'h00860086
  };

  // Neutral identification value, arbitrary
  localparam logic [31:0] DEVICE_ID_DEF = 32'h0000a5a5;

endpackage : host_regs_pkg
`default_nettype wire

// >>> rtl/host_register_map.sv
/*
  Register bank of an embedded high-speed USB host controller.
  Holds capability, operational and configuration registers behind a
  synchronous memory-mapped processor port, 32 or 16 bits wide.
  Assumes one clock, strobes one cycle wide and synchronous to clk_in.
*/
`timescale 1ns/1ps
`default_nettype none

module host_register_map
  import host_regs_pkg::*;
#(
  parameter logic [31:0] DEVICE_ID   = DEVICE_ID_DEF,
  parameter logic [3:0]  NUM_PORTS   = NUM_PORTS_DEF,
  parameter logic        PORT_POWER  = PORT_POWER_DEF
) (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic              cs_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  input  wire logic              bus16_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  output logic      [DATA_W-1:0] rdata_out,
  output logic                   ack_out,
  output logic                   half_pending_out,
  output logic      [DATA_W-1:0] scratch_out
);

  typedef struct packed {
    logic [NUM_WR-1:0][DATA_W-1:0] regs;
    logic [HALF_W-1:0]             wr_low;
    logic                          wr_low_ok;
    logic [DATA_W-1:0]             rd_hold;
    logic [DATA_W-1:0]             rdata;
    logic                          ack;
  } state_t;

  state_t st_q;
  state_t st_d;

  // Index of a writable register, or NUM_WR when none
  function automatic int unsigned wr_index(input logic [ADDR_W-1:0] a);
    int unsigned idx;
    idx = NUM_WR;
    for (int i = 0; i < NUM_WR; i++) begin
      if (WR_OFS[i] == a) begin
        idx = i;
      end
    end
    return idx;
  endfunction : wr_index

  function automatic state_t reset_state();
    state_t s;
    s = '0;
    for (int i = 0; i < NUM_WR; i++) begin
      s.regs[i] = WR_RST[i];
    end
    return s;
  endfunction : reset_state

  // Full 32-bit value seen at a word address
  function automatic logic [DATA_W-1:0] read_word(input state_t s,
                                                  input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    int unsigned       idx;
    v   = '0;
    idx = wr_index(a);
    if (a > SPACE_LAST) begin
      v = '0;
    end else if (a == OFS_CAP_LENGTH) begin
      v[7:0] = CAP_LENGTH_VAL;
      v[VERSION_LSB +: HALF_W] = IF_VERSION_VAL;
    end else if (a == OFS_STRUCT_PAR) begin
      v[NUM_PORTS_LSB +: 4]  = NUM_PORTS;
      v[PORT_POWER_BIT]      = PORT_POWER;
    end else if (a == OFS_CAP_PAR) begin
      v = CAP_PAR_VAL;
    end else if (a == OFS_DEVICE_ID) begin
      v = DEVICE_ID;
    end else if (a == OFS_SOFTWARE_RESET) begin
      v = '0;
    end else if (idx < NUM_WR) begin
      v = s.regs[idx];
    end else begin
      v = '0;
    end
    return v;
  endfunction : read_word

  logic [ADDR_W-1:0] word_addr;
  logic              high_half;
  logic              do_wr;
  logic              do_rd;

  assign word_addr = {addr_in[ADDR_W-1:2], 2'b00};
  assign high_half = addr_in[HALF_SEL_BIT];
  assign do_wr     = cs_in & wr_in;
  assign do_rd     = cs_in & rd_in & ~wr_in;

  always_comb begin
    logic [DATA_W-1:0] wval;
    logic              commit;
    logic [DATA_W-1:0] full;
    int unsigned       idx;
    wval   = '0;
    commit = 1'b0;
    full   = '0;
    idx    = NUM_WR;
    st_d       = st_q;
    st_d.ack   = 1'b0;

    // Write path: 32-bit at once, or low half held then high half commits
    if (do_wr) begin
      if (!bus16_in) begin
        wval   = wdata_in;
        commit = 1'b1;
      end else if (!high_half) begin
        st_d.wr_low    = wdata_in[HALF_W-1:0];
        st_d.wr_low_ok = 1'b1;
      end else begin
        wval           = {wdata_in[HALF_W-1:0], st_q.wr_low};
        commit         = st_q.wr_low_ok;
        st_d.wr_low_ok = 1'b0;
      end
      st_d.ack = 1'b1;
    end

    if (commit) begin
      idx = wr_index(word_addr);
      if (word_addr == OFS_SOFTWARE_RESET && wval[SOFTWARE_RESET_BIT]) begin
        st_d.regs = reset_state().regs;
      end else if (word_addr != OFS_SOFTWARE_RESET && idx < NUM_WR) begin
        st_d.regs[idx] = wval;
      end
    end

    // Read path: low half snapshots the whole word for the high half
    if (do_rd) begin
      full = read_word(st_q, word_addr);
      if (!bus16_in) begin
        st_d.rdata = full;
      end else if (!high_half) begin
        st_d.rd_hold = full;
        st_d.rdata   = {{HALF_W{1'b0}}, full[HALF_W-1:0]};
      end else begin
        st_d.rdata   = {{HALF_W{1'b0}}, st_q.rd_hold[DATA_W-1:HALF_W]};
      end
      st_d.ack = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= reset_state();
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_out        = st_q.rdata;
  assign ack_out          = st_q.ack;
  assign half_pending_out = st_q.wr_low_ok;
  assign scratch_out      = st_q.regs[17];

endmodule : host_register_map
`default_nettype wire

// >>> dv/host_map_checker.sv
/* Port checker for host_register_map. Assumes bind onto that module. */
`timescale 1ns/1ps
`default_nettype none
module host_map_checker
  import host_regs_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              nrst_in,
  input wire logic              cs_in,
  input wire logic              wr_in,
  input wire logic              rd_in,
  input wire logic              bus16_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire logic              ack_out,
  input wire logic              half_pending_out,
  input wire logic [DATA_W-1:0] scratch_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire logic       rq = cs_in && rd_in && !wr_in && !bus16_in;
  wire logic       wq = cs_in && wr_in;
  wire logic [7:0] w  = addr_in[9:2];
  a_ack_follows: assert property (
    cs_in && (wr_in || rd_in) |=> ack_out) else $error("no ack");
  a_ack_quiet: assert property (
    !(cs_in && (wr_in || rd_in)) |=> !ack_out) else $error("stray ack");
  a_cap_word: assert property (
    rq && w == 8'h00 |=> rdata_out == 32'h01000020) else $error("cap word");
  a_struct_val: assert property (
    rq && w == 8'h01 |=> rdata_out == 32'h00000011) else $error("struct");
  a_unused_zero: assert property (
    rq && addr_in[9:8] == 2'h2 |=> rdata_out == 32'h0) else $error("unused");
  a_rdata_hold: assert property (
    !(cs_in && rd_in && !wr_in) |=> $stable(rdata_out)) else $error("rdata");
  a_scratch_wr: assert property (
    wq && !bus16_in && w == 8'hc2 |=> scratch_out == $past(wdata_in)) else $error("scr");
  a_scratch_keep: assert property (
    !(wq && addr_in[9:3] == 7'h61) |=> $stable(scratch_out)) else $error("keep");
  a_half_held: assert property (
    wq && bus16_in && !addr_in[1] |=> half_pending_out) else $error("half");
  a_half_done: assert property (
    wq && bus16_in && addr_in[1] |=> !half_pending_out) else $error("commit");
  c_read: cover property (rq ##1 ack_out);
  c_high: cover property (wq && bus16_in && addr_in[1]);
  c_pend: cover property (half_pending_out);
endmodule : host_map_checker
bind host_register_map host_map_checker host_map_checker_i (.*);
`default_nettype wire

// >>> dv/host_cpu_model.sv
/* Host processor model: one access per call. Assumes ack one cycle after. */
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input  wire logic        clk_in,
  input  wire logic        ack_in,
  input  wire logic [31:0] rdata_in,
  output var  logic        cs_out,
  output var  logic        wr_out,
  output var  logic        rd_out,
  output var  logic [9:0]  addr_out,
  output var  logic [31:0] wdata_out
);
  initial {cs_out, wr_out, rd_out, addr_out, wdata_out} = '0;
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge clk_in);
    cs_out <= 1'b1;
    wr_out <= w;
    rd_out <= !w;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    cs_out <= 1'b0;
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    wdata_out <= ~d;
    #1;
    for (i = 0; i < 4 && ack_in !== 1'b1; i++) @(posedge clk_in) #1;
    q = rdata_in;
  endtask : acc
endmodule : host_cpu_model
`default_nettype wire

// >>> dv/test_usb_host_register_map.sv
/* Register bank testbench. Assumes host_cpu_model and the checker. */
`timescale 1ns/1ps
`default_nettype none
module test_usb_host_register_map
  import host_regs_pkg::*;
;
  logic        clk_in, nrst_in, cs, wr, rd, b16, ack, hp;
  logic [9:0]  addr;
  logic [31:0] wd, rdat, scr, q;
  int          n_fail = 0, checks = 0, i;
  host_register_map host_register_map_i (.clk_in(clk_in), .nrst_in(nrst_in), .cs_in(cs),
    .wr_in(wr), .rd_in(rd), .bus16_in(b16), .addr_in(addr), .wdata_in(wd),
    .rdata_out(rdat), .ack_out(ack), .half_pending_out(hp), .scratch_out(scr));
  host_cpu_model host_cpu_model_i (.clk_in(clk_in), .ack_in(ack), .rdata_in(rdat),
    .cs_out(cs), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wd));
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic wrt(input logic [9:0] a, input logic [31:0] d);
    host_cpu_model_i.acc(1'b1, a, d, q);
  endtask : wrt
  task automatic rc(input logic [9:0] a, input logic [31:0] e);
    host_cpu_model_i.acc(1'b0, a, 32'h0, q);
    chk($sformatf("rd %h", a), q, e);
  endtask : rc
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    n_fail++;
    give_verdict();
  end
  initial begin
    nrst_in = 1'b0;
    b16 = 1'b0;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    rc(10'h000, 32'h01000020);
    rc(10'h004, 32'h00000011);
    rc(10'h008, CAP_PAR_VAL);
    rc(10'h304, DEVICE_ID_DEF);
    for (i = 0; i < NUM_WR; i++) rc(WR_OFS[i], WR_RST[i]);
    wrt(10'h004, 32'hffffffff);
    wrt(10'h000, 32'hffffffff);
    wrt(10'h2fc, 32'h12345678);
    rc(10'h004, 32'h00000011);
    rc(10'h000, 32'h01000020);
    rc(10'h2fc, 32'h0);
    rc(10'h3fc, 32'h0);
    for (i = 0; i < NUM_WR; i++) begin
      if (WR_OFS[i] != OFS_SOFTWARE_RESET) wrt(WR_OFS[i], {22'h0, WR_OFS[i]} ^ 32'h5a5a0000);
    end
    for (i = 0; i < NUM_WR; i++) begin
      if (WR_OFS[i] != OFS_SOFTWARE_RESET) rc(WR_OFS[i], {22'h0, WR_OFS[i]} ^ 32'h5a5a0000);
    end
    chk("scratch", scr, 32'h5a5a0308);
    wrt(OFS_SOFTWARE_RESET, 32'h1);
    rc(10'h308, 32'h0);
    @(posedge clk_in);
    b16 <= 1'b1;
    wrt(10'h308, 32'h1234);
    chk("pending", {31'h0, hp}, 32'h1);
    wrt(10'h30a, 32'habcd);
    chk("pending", {31'h0, hp}, 32'h0);
    chk("scratch", scr, 32'habcd1234);
    rc(10'h000, 32'h0020);
    rc(10'h002, 32'h0100);
    rc(10'h004, 32'h0011);
    rc(10'h006, 32'h0000);
    give_verdict();
  end
endmodule : test_usb_host_register_map
`default_nettype wire
